//--- gpib_pkg.sv
// Purpose: constants and state types shared by both ends
// Assumes: bus lines carried in asserted sense (1 = line true)
// Notes: command bytes are compared with bit 7 masked off
package gpib_pkg;
    // address and command bytes
    localparam logic [7:0] CMD_UNL = 8'h3F;
    localparam logic [7:0] CMD_UNT = 8'h5F;
    localparam logic [7:0] LAD_BASE = 8'h20;
    localparam logic [7:0] TAD_BASE = 8'h40;
    localparam logic [1:0] GRP_TALK = 2'h2;
    localparam logic [7:0] CMD_GTL = 8'h01;
    localparam logic [7:0] CMD_SDC = 8'h04;
    localparam logic [7:0] CMD_PPC = 8'h05;
    localparam logic [7:0] CMD_GET = 8'h08;
    localparam logic [7:0] CMD_TCT = 8'h09;
    localparam logic [7:0] CMD_DCL = 8'h14;
    localparam logic [7:0] CMD_PPU = 8'h15;
    localparam logic [7:0] CMD_SPE = 8'h18;
    localparam logic [7:0] CMD_SPD = 8'h19;
    // primary address range and reset value
    localparam logic [4:0] ADDR_MAX = 5'h1E;
    localparam logic [4:0] ADDR_DEF = 5'h10;
    // status byte bit that carries the service request
    localparam int STB_RQS = 6;
    // data settle time before data valid
    localparam int CLK_PERIOD_NS = 5;
    localparam int SETTLE_NS = 2000;
    localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 10;
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    typedef enum logic [1:0] {ACC_IDLE, ACC_RDY, ACC_HOLD} acc_e;
    typedef enum logic [1:0] {SRC_IDLE, SRC_SETTLE, SRC_DAV} src_e;
    typedef enum logic [2:0] {CTL_IDLE, CTL_SETTLE, CTL_DAV, CTL_WAIT, CTL_HOLD} ctl_e;
endpackage : gpib_pkg

//--- gpib_bus_if.sv
// Purpose: the shared parallel bus between controller end and device end
// Assumes: lines driven by both ends are wired-OR in asserted sense; no party drives high-Z
// Notes: data lines resolve from each party's enable
`timescale 1ns/1ps
interface gpib_bus_if;
    // controller drives
    logic atnCtl, ifcCtl, renCtl, davCtl, eoiCtl, nrfdCtl, ndacCtl, dioCtlOe;
    logic [7:0] dioCtl;
    // device drives
    logic davDev, eoiDev, nrfdDev, ndacDev, srqDev, dioDevOe;
    logic [7:0] dioDev;
    // resolved bus
    logic atn, ifc, ren, dav, eoi, nrfd, ndac, srq;
    logic [7:0] dio;
    // wired-OR resolution
    assign atn = atnCtl;
    assign ifc = ifcCtl;
    assign ren = renCtl;
    assign dav = davCtl | davDev;
    assign eoi = eoiCtl | eoiDev;
    assign nrfd = nrfdCtl | nrfdDev;
    assign ndac = ndacCtl | ndacDev;
    assign srq = srqDev;
    assign dio = (dioCtlOe ? dioCtl : 8'h00) | (dioDevOe ? dioDev : 8'h00);
    modport device (
        input atn, ifc, ren, dav, eoi, nrfd, ndac, dio,
        output davDev, eoiDev, nrfdDev, ndacDev, srqDev, dioDevOe, dioDev
    );
    modport controller (
        input dav, eoi, nrfd, ndac, srq, dio,
        output atnCtl, ifcCtl, renCtl, davCtl, eoiCtl, nrfdCtl, ndacCtl, dioCtlOe, dioCtl
    );
endinterface : gpib_bus_if

//--- gpib_controller.sv
// Purpose: bus controller end: sends bytes with or without attention, reads bytes
// Assumes: user orders unlisten, address and command bytes itself
// Notes: one byte per request; waits for a listener before data valid
`timescale 1ns/1ps
module gpib_controller import gpib_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    gpib_bus_if.controller bus,
    input wire logic reqValid,
    input wire logic reqRead,
    input wire logic reqAtn,
    input wire logic [7:0] reqByte,
    input wire logic reqEnd,
    output logic reqReady,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic rdEnd,
    input wire logic renIn,
    input wire logic ifcIn,
    output logic srqSeen
);
    ctl_e st_r;
    logic [12:0] syncA_r, syncB_r;
    logic davS, eoiS, nrfdS, ndacS, srqS;
    logic [7:0] dioS;
    logic [CNT_W-1:0] cnt_r;
    logic atn_r, dav_r, eoi_r, nrfd_r, ndac_r, oe_r, ren_r, ifc_r;
    logic [7:0] dio_r, rdData_r;
    logic ready_r, rdValid_r, rdEnd_r, srq_r;
    logic take;

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers on the bus lines
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            syncA_r <= 13'h0000;
            syncB_r <= 13'h0000;
        end else begin
            syncA_r <= {bus.dav, bus.eoi, bus.nrfd, bus.ndac, bus.srq, bus.dio};
            syncB_r <= syncA_r;
        end
    end
    assign {davS, eoiS, nrfdS, ndacS, srqS, dioS} = syncB_r;
    assign take = reqValid && ready_r;

    ////////////////////////////////////////////////////////////////////////
    // ren and ifc follow the user levels; srqSeen follows the synchronised srq line
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ren_r <= 1'b0;
            ifc_r <= 1'b0;
            srq_r <= 1'b0;
        end else begin
            ren_r <= renIn;
            ifc_r <= ifcIn;
            srq_r <= srqS;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source and acceptor handshake for one byte per request
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_r <= CTL_IDLE;
            {atn_r, dav_r, eoi_r, nrfd_r, ndac_r, oe_r} <= 6'h00;
            {ready_r, rdValid_r, rdEnd_r} <= 3'h0;
            dio_r <= 8'h00;
            rdData_r <= 8'h00;
            cnt_r <= '0;
        end else begin
            rdValid_r <= 1'b0;
            unique case (st_r)
                CTL_IDLE: begin
                    ready_r <= !take;
                    if (take && reqRead) begin
                        atn_r <= 1'b0;
                        ndac_r <= 1'b1;
                        st_r <= CTL_WAIT;
                    end else if (take) begin
                        atn_r <= reqAtn; // ATN stays as set across a command run
                        dio_r <= reqByte;
                        eoi_r <= reqEnd;
                        oe_r <= atn_r || !reqAtn;
                        cnt_r <= '0;
                        st_r <= CTL_SETTLE;
                    end
                end
                CTL_SETTLE: begin
                    if (cnt_r != SETTLE_LAST) begin
                        cnt_r <= cnt_r + CNT_ONE;
                    end else if (!oe_r) begin // a talker has seen attention
                        oe_r <= 1'b1;
                        cnt_r <= '0;
                    end else if (!nrfdS && ndacS) begin
                        dav_r <= 1'b1;
                        st_r <= CTL_DAV;
                    end
                end
                CTL_DAV: begin
                    if (!ndacS) begin
                        {dav_r, oe_r, eoi_r} <= 3'h0;
                        st_r <= CTL_IDLE;
                    end
                end
                CTL_WAIT: begin
                    if (davS) begin
                        rdData_r <= dioS;
                        rdEnd_r <= eoiS;
                        rdValid_r <= 1'b1;
                        nrfd_r <= 1'b1;
                        ndac_r <= 1'b0;
                        st_r <= CTL_HOLD;
                    end
                end
                CTL_HOLD: begin
                    if (!davS) begin
                        nrfd_r <= 1'b0;
                        st_r <= CTL_IDLE;
                    end
                end
            endcase
        end
    end

    assign bus.atnCtl = atn_r;
    assign bus.ifcCtl = ifc_r;
    assign bus.renCtl = ren_r;
    assign bus.davCtl = dav_r;
    assign bus.eoiCtl = eoi_r;
    assign bus.nrfdCtl = nrfd_r;
    assign bus.ndacCtl = ndac_r;
    assign bus.dioCtlOe = oe_r;
    assign bus.dioCtl = dio_r;
    assign reqReady = ready_r;
    assign rdData = rdData_r;
    assign rdValid = rdValid_r;
    assign rdEnd = rdEnd_r;
    assign srqSeen = srq_r;
endmodule : gpib_controller

//--- gpib_device.sv
// Purpose: instrument end of the parallel port: addressing, handshakes, polls
// Assumes: bus lines arrive from pins and are synchronised here
// Notes: no parallel poll, no controller role, no secondary addressing
//
// How it works
// - addressed commands ignored until own listen address
// - controller opens with unlisten under attention
// - listen address is 20h plus own address
// - selective clear under attention is a command
// - bytes without attention while listening are data
// - talks only when addressed; listen address ends talking
// - listens only when addressed; talk address ends listening
// - data valid only after not-ready released
// - full acceptor handshake, each byte taken once
// - service request line and serial poll status byte
// - remote under enable when addressed; local on command
// - never answers nor drives parallel poll
// - device clear universal, or selective when listening
// - trigger command while listening starts a reading
// - never drives attention, clear, remote; no secondaries
// - poll configure and take control ignored
// - configured address only ever 0 to 30
`timescale 1ns/1ps
module gpib_device import gpib_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    gpib_bus_if.device bus,
    input wire logic [4:0] cfgAddr,
    input wire logic cfgLoad,
    input wire logic [7:0] txData,
    input wire logic txValid,
    input wire logic txEnd,
    output logic txReady,
    output logic [7:0] rxData,
    output logic rxValid,
    output logic rxEnd,
    input wire logic svcReq,
    input wire logic [7:0] stbIn,
    output logic devClear,
    output logic devTrigger,
    output logic remote,
    output logic listening,
    output logic talking,
    output logic [4:0] addrOut
);
    acc_e acc_r;
    src_e src_r;
    logic [14:0] syncA_r, syncB_r;
    logic atnS, ifcS, renS, davS, eoiS, nrfdS, ndacS;
    logic [7:0] dioS;
    logic [4:0] addr_r;
    logic [7:0] byte_r;
    logic byteEoi_r, byteAtn_r, take_r;
    logic nrfdDev_r, ndacDev_r;
    logic listen_r, talk_r, spMode_r, remote_r;
    logic rxValid_r, rxEnd_r, clear_r, trig_r;
    logic [7:0] rxData_r;
    logic [7:0] dioDev_r;
    logic dioOe_r, davDev_r, eoiDev_r, txReady_r;
    logic [CNT_W-1:0] cnt_r;
    logic srq_r, polled_r;
    logic [7:0] cmd;
    logic accActive, talkAct, cmdTake, spSent;

    // true when the byte is the given group base plus our address
    function automatic logic isAddr(input logic [7:0] b, input logic [7:0] base,
                                    input logic [4:0] a);
        isAddr = (b == (base | {3'h0, a}));
    endfunction : isAddr

    ////////////////////////////////////////////////////////////////////////
    // two-flop synchronisers on every bus line read here
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            syncA_r <= 15'h0000;
            syncB_r <= 15'h0000;
        end else begin
            syncA_r <= {bus.atn, bus.ifc, bus.ren, bus.dav, bus.eoi, bus.nrfd,
                        bus.ndac, bus.dio};
            syncB_r <= syncA_r;
        end
    end
    assign {atnS, ifcS, renS, davS, eoiS, nrfdS, ndacS, dioS} = syncB_r;

    ////////////////////////////////////////////////////////////////////////
    // primary address, loaded only when in range
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_r <= ADDR_DEF;
        end else if (cfgLoad && cfgAddr <= ADDR_MAX) begin
            addr_r <= cfgAddr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // acceptor handshake: commands always, data only while listening
    assign accActive = atnS || listen_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_r <= ACC_IDLE;
            nrfdDev_r <= 1'b0;
            ndacDev_r <= 1'b0;
            byte_r <= 8'h00;
            byteEoi_r <= 1'b0;
            byteAtn_r <= 1'b0;
            take_r <= 1'b0;
        end else begin
            take_r <= 1'b0;
            unique case (acc_r)
                ACC_IDLE: begin
                    if (accActive && !davS) begin
                        ndacDev_r <= 1'b1;
                        acc_r <= ACC_RDY;
                    end
                end
                ACC_RDY: begin
                    if (!accActive) begin
                        ndacDev_r <= 1'b0;
                        acc_r <= ACC_IDLE;
                    end else if (davS) begin // capture once, then hold off
                        byte_r <= dioS;
                        byteEoi_r <= eoiS;
                        byteAtn_r <= atnS;
                        take_r <= 1'b1;
                        nrfdDev_r <= 1'b1;
                        ndacDev_r <= 1'b0;
                        acc_r <= ACC_HOLD;
                    end
                end
                ACC_HOLD: begin
                    if (!davS) begin // rearm only after data valid drops
                        nrfdDev_r <= 1'b0;
                        ndacDev_r <= accActive;
                        acc_r <= accActive ? ACC_RDY : ACC_IDLE;
                    end
                end
            endcase
        end
    end

    // command byte with bit 7 ignored; taken only under attention
    assign cmd = {1'b0, byte_r[6:0]};
    assign cmdTake = take_r && byteAtn_r;

    ////////////////////////////////////////////////////////////////////////
    // listener and talker addressing
    always_ff @(posedge sys_clk) begin
        if (rst || ifcS) begin
            listen_r <= 1'b0;
            talk_r <= 1'b0;
        end else if (cmdTake) begin
            if (cmd == CMD_UNL) begin
                listen_r <= 1'b0;
            end else if (cmd == CMD_UNT) begin
                talk_r <= 1'b0;
            end else if (isAddr(cmd, LAD_BASE, addr_r)) begin
                listen_r <= 1'b1;
                talk_r <= 1'b0;
            end else if (isAddr(cmd, TAD_BASE, addr_r)) begin
                talk_r <= 1'b1;
                listen_r <= 1'b0;
            end else if (cmd[6:5] == GRP_TALK) begin
                talk_r <= 1'b0; // another talker addressed
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial poll mode
    always_ff @(posedge sys_clk) begin
        if (rst || ifcS) begin
            spMode_r <= 1'b0;
        end else if (cmdTake && cmd == CMD_SPE) begin
            spMode_r <= 1'b1;
        end else if (cmdTake && cmd == CMD_SPD) begin
            spMode_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // remote and local
    always_ff @(posedge sys_clk) begin
        if (rst || !renS) begin
            remote_r <= 1'b0;
        end else if (cmdTake && isAddr(cmd, LAD_BASE, addr_r)) begin
            remote_r <= 1'b1;
        end else if (cmdTake && cmd == CMD_GTL && listen_r) begin
            remote_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clear and trigger pulses; poll configure, take control and
    // secondaries fall through with no effect
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clear_r <= 1'b0;
            trig_r <= 1'b0;
        end else begin
            clear_r <= cmdTake && (cmd == CMD_DCL
                       || (cmd == CMD_SDC && listen_r));
            trig_r <= cmdTake && cmd == CMD_GET && listen_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // received data bytes
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rxValid_r <= 1'b0;
            rxEnd_r <= 1'b0;
            rxData_r <= 8'h00;
        end else begin
            rxValid_r <= take_r && !byteAtn_r && listen_r;
            if (take_r) begin
                rxData_r <= byte_r;
                rxEnd_r <= byteEoi_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // source handshake: drives only when talking and attention is off
    assign talkAct = talk_r && !atnS;
    assign spSent = src_r == SRC_DAV && !ndacS && spMode_r && dioDev_r[STB_RQS];
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            src_r <= SRC_IDLE;
            {dioOe_r, davDev_r, eoiDev_r, txReady_r} <= 4'h0;
            dioDev_r <= 8'h00;
            cnt_r <= '0;
        end else if (!talkAct || clear_r) begin // clear drops pending byte
            src_r <= SRC_IDLE;
            {dioOe_r, davDev_r, eoiDev_r, txReady_r} <= 4'h0;
        end else begin
            txReady_r <= 1'b0;
            unique case (src_r)
                SRC_IDLE: begin
                    cnt_r <= '0;
                    if (spMode_r) begin // status byte with service bit
                        dioDev_r <= {stbIn[7], srq_r, stbIn[5:0]};
                        eoiDev_r <= 1'b0;
                        dioOe_r <= 1'b1;
                        src_r <= SRC_SETTLE;
                    end else if (txValid && txReady_r) begin
                        dioDev_r <= txData;
                        eoiDev_r <= txEnd;
                        dioOe_r <= 1'b1;
                        src_r <= SRC_SETTLE;
                    end else begin
                        txReady_r <= 1'b1;
                    end
                end
                SRC_SETTLE: begin
                    if (cnt_r != SETTLE_LAST) begin
                        cnt_r <= cnt_r + CNT_ONE;
                    end else if (!nrfdS && ndacS) begin
                        davDev_r <= 1'b1;
                        src_r <= SRC_DAV;
                    end
                end
                SRC_DAV: begin
                    if (!ndacS) begin
                        {dioOe_r, davDev_r, eoiDev_r} <= 3'h0;
                        src_r <= SRC_IDLE;
                    end
                end
                default: src_r <= SRC_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // service request until polled with the service bit set
    always_ff @(posedge sys_clk) begin
        if (rst || !svcReq) begin
            polled_r <= 1'b0;
            srq_r <= 1'b0;
        end else begin
            if (spSent) begin
                polled_r <= 1'b1;
            end
            srq_r <= !polled_r && !spSent;
        end
    end

    assign bus.davDev = davDev_r;
    assign bus.eoiDev = eoiDev_r;
    assign bus.nrfdDev = nrfdDev_r;
    assign bus.ndacDev = ndacDev_r;
    assign bus.srqDev = srq_r;
    assign bus.dioDevOe = dioOe_r;
    assign bus.dioDev = dioDev_r;
    assign txReady = txReady_r;
    assign rxData = rxData_r;
    assign rxValid = rxValid_r;
    assign rxEnd = rxEnd_r;
    assign devClear = clear_r;
    assign devTrigger = trig_r;
    assign remote = remote_r;
    assign listening = listen_r;
    assign talking = talk_r;
    assign addrOut = addr_r;
endmodule : gpib_device

//--- gpib_link_monitor.sv
// Purpose: protocol checks on the bus between the two ends
// Assumes: lines in asserted sense, one clock domain
// Notes: a helper counter measures device data setup
`timescale 1ns/1ps
module gpib_link_monitor import gpib_pkg::*; (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic atn,
    input wire logic nrfd,
    input wire logic ndac,
    input wire logic davDev,
    input wire logic nrfdDev,
    input wire logic ndacDev,
    input wire logic dioDevOe,
    input wire logic [7:0] dioDev,
    input wire logic davCtl,
    input wire logic nrfdCtl,
    input wire logic ndacCtl,
    input wire logic dioCtlOe,
    input wire logic [7:0] dioCtl
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [CNT_W-1:0] settleCnt_r;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // cycles of device data drive, saturating
    always_ff @(posedge sys_clk) begin
        if (rst || !dioDevOe) begin
            settleCnt_r <= '0;
        end else if (settleCnt_r != SETTLE_LAST) begin
            settleCnt_r <= settleCnt_r + CNT_ONE;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // handshake order and data stability
    dev_dav_ready_a: assert property ($rose(davDev) |-> !nrfd && ndac)
        else $error("device dav before ready");
    ctl_dav_ready_a: assert property ($rose(davCtl) |-> !nrfd && ndac)
        else $error("controller dav before ready");
    dev_data_hold_a: assert property (davDev |-> dioDevOe && $stable(dioDev))
        else $error("device data moved under dav");
    ctl_data_hold_a: assert property (davCtl |-> dioCtlOe && $stable(dioCtl))
        else $error("controller data moved under dav");
    settle_time_a: assert property ($rose(davDev) |-> settleCnt_r == SETTLE_LAST)
        else $error("device dav before settle");
    dev_accept_a: assert property (($rose(davCtl) && ndacDev) |-> ##[1:8] (!ndacDev && nrfdDev))
        else $error("device did not accept byte");
    ctl_accept_a: assert property (($rose(davDev) && ndacCtl) |-> ##[1:8] (!ndacCtl && nrfdCtl))
        else $error("controller did not accept byte");
    dav_release_a: assert property ((davDev && $fell(ndac)) |-> ##[1:8] !davDev)
        else $error("device dav held after accept");
    quiet_atn_a: assert property (atn [*5] |-> !dioDevOe && !davDev)
        else $error("device drove data under atn");
    one_driver_a: assert property (!(dioDevOe && dioCtlOe))
        else $error("both ends drove data lines");
endmodule : gpib_link_monitor

//--- ieee488_device_interface_test.sv
// Purpose: self-checking bench joining controller end and device end
// Assumes: inputs change at the falling edge; expected bytes queued by the driver
// Notes: a watcher pops the oldest expected byte whenever a byte is delivered
`timescale 1ns/1ps
module ieee488_device_interface_test import gpib_pkg::*;;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic reqValid, reqRead, reqAtn, reqEnd, reqReady, rdValid, rdEnd, renIn, ifcIn, srqSeen;
    logic cfgLoad, txValid, txEnd, txReady, rxValid, rxEnd, svcReq, devClear, devTrigger;
    logic remote, listening, talking;
    logic [7:0] reqByte, rdData, txData, rxData, stbIn, obs, b;
    logic [4:0] cfgAddr, addrOut;
    int errors, compares, clrCnt, trigCnt;
    logic [7:0] expQ[$];
    gpib_bus_if bus();
    always #2.5 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////////////
    gpib_controller i_gpib_controller (.sys_clk, .rst, .bus, .reqValid, .reqRead, .reqAtn,
        .reqByte, .reqEnd, .reqReady, .rdData, .rdValid, .rdEnd, .renIn, .ifcIn, .srqSeen);
    gpib_device i_gpib_device (.sys_clk, .rst, .bus, .cfgAddr, .cfgLoad, .txData, .txValid,
        .txEnd, .txReady, .rxData, .rxValid, .rxEnd, .svcReq, .stbIn, .devClear, .devTrigger,
        .remote, .listening, .talking, .addrOut);
    gpib_link_monitor i_gpib_link_monitor (.sys_clk, .rst, .atn(bus.atn),
        .nrfd(bus.nrfd), .ndac(bus.ndac), .davDev(bus.davDev), .nrfdDev(bus.nrfdDev),
        .ndacDev(bus.ndacDev), .dioDevOe(bus.dioDevOe), .dioDev(bus.dioDev),
        .davCtl(bus.davCtl), .nrfdCtl(bus.nrfdCtl), .ndacCtl(bus.ndacCtl),
        .dioCtlOe(bus.dioCtlOe), .dioCtl(bus.dioCtl));
    ////////////////////////////////////////////////////////////////////////////////
    // one comparison, counted and reported
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    // one controller request, held until taken, then until rearmed
    task automatic send(input logic rd, input logic atnOn, input logic [7:0] v);
        @(negedge sys_clk);
        reqValid = 1'h1;
        reqRead = rd;
        reqAtn = atnOn;
        reqByte = v;
        while (reqReady !== 1'h1) @(negedge sys_clk);
        @(negedge sys_clk);
        reqValid = 1'h0;
        while (reqReady !== 1'h1) @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
    endtask : send
    // one talker byte offered by the device user side
    task automatic tx(input logic [7:0] v);
        @(negedge sys_clk);
        txData = v;
        txValid = 1'h1;
        while (txReady !== 1'h1) @(negedge sys_clk);
        @(negedge sys_clk);
        txValid = 1'h0;
    endtask : tx
    // controller reads one byte; the device user sources it unless polled
    task automatic rd(input logic [7:0] v, input logic poll);
        expQ.push_back(v);
        fork
            send(1'h1, 1'h0, 8'h00);
            if (!poll) tx(v);
        join
    endtask : rd
    task automatic load(input logic [4:0] a);
        @(negedge sys_clk);
        cfgAddr = a;
        cfgLoad = 1'h1;
        @(negedge sys_clk);
        cfgLoad = 1'h0;
        repeat (2) @(negedge sys_clk);
    endtask : load
    task automatic end_sim();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    ////////////////////////////////////////////////////////////////////////////////
    // watcher: pulse counts and delivered bytes against the oldest note
    always @(negedge sys_clk) begin
        if (devClear === 1'h1) clrCnt++;
        if (devTrigger === 1'h1) trigCnt++;
        if (rxValid === 1'h1 || rdValid === 1'h1) begin
            obs = (rxValid === 1'h1) ? rxData : rdData;
            if (expQ.size() != 0) chk("byte", expQ.pop_front(), obs);
            else chk("stray byte", ~obs, obs);
        end
    end
    initial begin
        #400000;
        errors++;
        $display("watchdog expired");
        end_sim();
    end
    // main sequence
    initial begin
        {reqValid, reqRead, reqAtn, reqEnd, renIn, ifcIn, cfgLoad, txValid, txEnd} = '0;
        {reqByte, txData, stbIn, cfgAddr, svcReq} = '0;
        void'($urandom(32'h3615));
        repeat (20) @(negedge sys_clk);
        rst = 1'h0;
        repeat (3) @(negedge sys_clk);
        chk("addrOut", 8'h10, {3'h0, addrOut});
        load(5'h1F);
        chk("addrOut", 8'h10, {3'h0, addrOut});
        load(ADDR_MAX);
        chk("addrOut", {3'h0, ADDR_MAX}, {3'h0, addrOut});
        load(ADDR_DEF);
        $display("test address done");
        send(1'h0, 1'h1, CMD_UNL);
        send(1'h0, 1'h1, CMD_GET);
        send(1'h0, 1'h1, CMD_SDC);
        chk("trigger count", 8'h00, trigCnt[7:0]);
        chk("clear count", 8'h00, clrCnt[7:0]);
        $display("test unaddressed done");
        renIn = 1'h1;
        send(1'h0, 1'h1, LAD_BASE + 8'h10);
        chk("listening", 8'h01, {7'h00, listening});
        chk("remote", 8'h01, {7'h00, remote});
        send(1'h0, 1'h1, CMD_SDC);
        chk("clear count", 8'h01, clrCnt[7:0]);
        send(1'h0, 1'h1, CMD_GET);
        chk("trigger count", 8'h01, trigCnt[7:0]);
        send(1'h0, 1'h1, CMD_PPC);
        send(1'h0, 1'h1, CMD_TCT);
        chk("state", 8'h01, {6'h00, talking, listening});
        send(1'h0, 1'h1, CMD_GTL);
        chk("remote", 8'h00, {7'h00, remote});
        $display("test commands done");
        expQ.push_back(8'h2A);
        send(1'h0, 1'h0, 8'h2A);
        for (int i = 0; i < 3; i++) begin
            b = 8'($urandom);
            expQ.push_back(b);
            send(1'h0, 1'h0, b);
        end
        chk("pending bytes", 8'h00, 8'(expQ.size()));
        $display("test listen data done");
        send(1'h0, 1'h1, TAD_BASE + 8'h10);
        chk("state", 8'h02, {6'h00, talking, listening});
        for (int i = 0; i < 3; i++) rd(8'($urandom), 1'h0);
        send(1'h0, 1'h1, LAD_BASE + 8'h10);
        chk("state", 8'h01, {6'h00, talking, listening});
        send(1'h0, 1'h1, CMD_UNL);
        chk("listening", 8'h00, {7'h00, listening});
        $display("test talk done");
        stbIn = 8'($urandom);
        svcReq = 1'h1;
        repeat (10) @(negedge sys_clk);
        chk("srqSeen", 8'h01, {7'h00, srqSeen});
        send(1'h0, 1'h1, CMD_SPE);
        send(1'h0, 1'h1, TAD_BASE + 8'h10);
        rd({stbIn[7], 1'h1, stbIn[5:0]}, 1'h1);
        send(1'h0, 1'h1, CMD_SPD);
        send(1'h0, 1'h1, CMD_UNT);
        chk("talking", 8'h00, {7'h00, talking});
        chk("srqSeen", 8'h00, {7'h00, srqSeen});
        send(1'h0, 1'h1, CMD_DCL);
        chk("clear count", 8'h02, clrCnt[7:0]);
        $display("test poll and clear done");
        end_sim();
    end
endmodule : ieee488_device_interface_test
